/* File: src/tfsa_frame_slot_access.sv */
// Frame interface timing and four controller slot-access registers
`timescale 1ns/1ps
`include "tfsa_regs.svh"
module tfsa_frame_slot_access
#(
  parameter int FRAME_CYCLES = `TFSA_FRAME_NS / `TFSA_CLK_NS
)
(
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire tfsa_pkg::tfsa_word_type HADDR_I,
  input wire tfsa_pkg::tfsa_htrans_type HTRANS_I,
  input wire logic HWRITE_I,
  input wire tfsa_pkg::tfsa_hsize_type HSIZE_I,
  input wire tfsa_pkg::tfsa_word_type HWDATA_I,
  input wire logic HREADY_I,
  output tfsa_pkg::tfsa_word_type HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic FRAME_SYNC_I,
  input wire logic DOUBLE_RATE_CLOCK_I,
  output logic BIT_RATE_CLOCK_O,
  input wire logic UPSTREAM_LINE_I,
  output logic UPSTREAM_LINE_O,
  output logic UPSTREAM_LINE_OE_O,
  input wire logic DOWNSTREAM_LINE_I,
  output logic DOWNSTREAM_LINE_O,
  output logic DOWNSTREAM_LINE_OE_O
);
  import tfsa_pkg::*;

  localparam logic [15:0] LOST_LIMIT = 16'(2 * FRAME_CYCLES);

  tfsa_state_type s;
  tfsa_state_type next_s;
  logic fs_rise;
  logic dcl_rise;
  logic dcl_fall;
  logic take;
  logic cap_now;
  logic [7:0] up_byte;
  logic [7:0] dn_byte;
  logic [3:0] cap_hit;
  logic [3:0] bus_dat_wr;

  // Enable bit of member y, input or output side
  function automatic logic en_bit(input logic [4:0] pcr, input logic y,
                                  input logic inp);
    logic r;
    if (inp)
    begin
      r = y ? pcr[`TFSA_PCR_IEN1] : pcr[`TFSA_PCR_IEN0];
    end
    else
    begin
      r = y ? pcr[`TFSA_PCR_OEN1] : pcr[`TFSA_PCR_OEN0];
    end
    return r;
  endfunction

  // Register whose selection steers the input of register k
  function automatic logic [1:0] src_idx(input logic [1:0] k,
                                         input logic swap);
    return swap ? {k[1], ~k[0]} : k;
  endfunction

  // Bits go out most significant first
  function automatic logic pick_bit(input logic [7:0] b,
                                    input logic [2:0] pos);
    return b[`TFSA_MSB_POS - pos];
  endfunction

  // Drive value and enable of one line for a bit position
  function automatic logic [1:0] drive_line(input logic up,
                                            input logic [6:0] bitc,
                                            input tfsa_state_type st);
    logic oe;
    logic v;
    oe = 1'b0;
    v = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      // Output slot and line never depend on swap
      if (en_bit(st.pcr[k >> 1], 1'(k), 1'b0) &&
          st.sps[k][3:0] == bitc[6:3] &&
          st.sps[k][`TFSA_SPS_PORT] == up)
      begin
        oe = 1'b1;
        v = pick_bit(st.data[k], bitc[2:0]);
      end
    end
    return {oe, v};
  endfunction

  function automatic logic ci_pos(input logic [2:0] pos);
    return pos >= `TFSA_CI_POS_FIRST && pos <= `TFSA_CI_POS_LAST;
  endfunction

  function automatic tfsa_word_type rd_word(input logic [7:0] a,
                                            input tfsa_state_type st);
    tfsa_word_type w;
    w = '0;
    if (a == `TFSA_OFF_IFCTRL)
    begin
      w[1:0] = st.ifc;
    end
    else if (a == `TFSA_OFF_SPS10)
    begin
      w[7:0] = st.sps[0];
    end
    else if (a == `TFSA_OFF_SPS11)
    begin
      w[7:0] = st.sps[1];
    end
    else if (a == `TFSA_OFF_SPS20)
    begin
      w[7:0] = st.sps[2];
    end
    else if (a == `TFSA_OFF_SPS21)
    begin
      w[7:0] = st.sps[3];
    end
    else if (a == `TFSA_OFF_PCR1)
    begin
      w[4:0] = st.pcr[0];
    end
    else if (a == `TFSA_OFF_PCR2)
    begin
      w[4:0] = st.pcr[1];
    end
    else if (a == `TFSA_OFF_DAT10)
    begin
      w[7:0] = st.data[0];
    end
    else if (a == `TFSA_OFF_DAT11)
    begin
      w[7:0] = st.data[1];
    end
    else if (a == `TFSA_OFF_DAT20)
    begin
      w[7:0] = st.data[2];
    end
    else if (a == `TFSA_OFF_DAT21)
    begin
      w[7:0] = st.data[3];
    end
    else if (a == `TFSA_OFF_STATUS)
    begin
      w[`TFSA_ST_VALID] = st.frame_valid;
      w[`TFSA_ST_LOST] = st.fcnt == LOST_LIMIT;
      w[`TFSA_ST_FCNT_LSB +: 8] = st.frames;
    end
    return w;
  endfunction

  assign fs_rise = s.fs_s2 & ~s.fs_d;
  assign dcl_rise = s.dcl_s2 & ~s.dcl_d;
  assign dcl_fall = ~s.dcl_s2 & s.dcl_d;
  assign take = HSEL_I && HTRANS_I[1] && HREADY_I &&
                HSIZE_I == `TFSA_HSIZE_WORD;
  // Capture on the falling edge closing the second half of a bit
  assign cap_now = dcl_fall && s.half && s.frame_valid && RESETN_I &&
                   !s.ifc[`TFSA_IFC_DIS] && s.bit_cnt[2:0] == `TFSA_POS_LAST;
  assign up_byte = {s.rx_up[6:0], s.up_s2};
  assign dn_byte = {s.rx_dn[6:0], s.dn_s2};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_cap
      logic [1:0] j;
      assign j = src_idx(2'(g), s.pcr[g >> 1][`TFSA_PCR_SWAP]);
      assign cap_hit[g] = cap_now &&
                          en_bit(s.pcr[g >> 1], 1'(g), 1'b1) &&
                          s.sps[j][3:0] == s.bit_cnt[6:3];
      assign bus_dat_wr[g] = s.ad_valid && s.ad_write && RESETN_I &&
                             s.ad_addr == 8'(`TFSA_OFF_DAT10 + 4 * g);
    end
  endgenerate

  always_comb
  begin
    next_s = s;
    next_s.fs_s1 = FRAME_SYNC_I;
    next_s.fs_s2 = s.fs_s1;
    next_s.fs_d = s.fs_s2;
    next_s.dcl_s1 = DOUBLE_RATE_CLOCK_I;
    next_s.dcl_s2 = s.dcl_s1;
    next_s.dcl_d = s.dcl_s2;
    next_s.up_s1 = UPSTREAM_LINE_I;
    next_s.up_s2 = s.up_s1;
    next_s.dn_s1 = DOWNSTREAM_LINE_I;
    next_s.dn_s2 = s.dn_s1;
    next_s.rst_d = ~RESETN_I;
    // Frame timing runs whether or not reset is held
    if (fs_rise)
    begin
      next_s.fs_pend = 1'b1;
      next_s.frames = s.frames + 8'h01;
    end
    if (dcl_rise)
    begin
      if (fs_rise || s.fs_pend)
      begin
        next_s.bit_cnt = '0;
        next_s.half = 1'b0;
        next_s.fs_pend = 1'b0;
        next_s.frame_valid = 1'b1;
      end
      else if (s.half)
      begin
        next_s.half = 1'b0;
        next_s.bit_cnt = (s.bit_cnt == `TFSA_BIT_LAST) ? '0 :
                         s.bit_cnt + 7'h01;
      end
      else
      begin
        next_s.half = 1'b1;
      end
      next_s.bit_rate_clock = ~next_s.half;
    end
    if (fs_rise)
    begin
      next_s.fcnt = '0;
    end
    else if (s.fcnt != LOST_LIMIT)
    begin
      next_s.fcnt = s.fcnt + 16'h0001;
    end
    if (dcl_fall && s.half)
    begin
      next_s.rx_up = up_byte;
      next_s.rx_dn = dn_byte;
    end
    // Hazard: a bus write and a capture in one cycle, capture wins
    for (int k = 0; k < 4; k++)
    begin
      if (bus_dat_wr[k])
      begin
        next_s.data[k] = HWDATA_I[7:0];
      end
      if (cap_hit[k])
      begin
        // Input line is the one opposite the selected output line
        next_s.data[k] = s.sps[src_idx(2'(k),
          s.pcr[k >> 1][`TFSA_PCR_SWAP])][`TFSA_SPS_PORT] ?
          dn_byte : up_byte;
      end
    end
    // Reads wait one cycle so the data phase shows registered data
    if (s.ad_valid && !s.ad_write && !s.hreadyout)
    begin
      next_s.hrdata = rd_word(s.ad_addr, s);
      next_s.hreadyout = 1'b1;
      next_s.ad_valid = 1'b0;
    end
    else
    begin
      if (s.ad_valid && s.ad_write)
      begin
        if (s.ad_addr == `TFSA_OFF_IFCTRL)
        begin
          next_s.ifc = HWDATA_I[1:0];
        end
        else if (s.ad_addr == `TFSA_OFF_SPS10)
        begin
          next_s.sps[0] = HWDATA_I[7:0];
        end
        else if (s.ad_addr == `TFSA_OFF_SPS11)
        begin
          next_s.sps[1] = HWDATA_I[7:0];
        end
        else if (s.ad_addr == `TFSA_OFF_SPS20)
        begin
          next_s.sps[2] = HWDATA_I[7:0];
        end
        else if (s.ad_addr == `TFSA_OFF_SPS21)
        begin
          next_s.sps[3] = HWDATA_I[7:0];
        end
        else if (s.ad_addr == `TFSA_OFF_PCR1)
        begin
          next_s.pcr[0] = HWDATA_I[4:0];
        end
        else if (s.ad_addr == `TFSA_OFF_PCR2)
        begin
          next_s.pcr[1] = HWDATA_I[4:0];
        end
      end
      next_s.ad_valid = take;
      next_s.ad_write = HWRITE_I;
      next_s.ad_addr = HADDR_I[7:0];
      next_s.hreadyout = !(take && !HWRITE_I);
    end
    if (!RESETN_I)
    begin
      next_s.ifc = `TFSA_RST_IFC;
      next_s.sps = {4{`TFSA_RST_SPS}};
      next_s.pcr = {2{`TFSA_RST_PCR}};
      next_s.data = {4{`TFSA_RST_DATA}};
      next_s.ad_valid = 1'b0;
      next_s.ad_write = 1'b0;
      next_s.ad_addr = '0;
      next_s.hreadyout = 1'b1;
      next_s.hrdata = '0;
      next_s.fcnt = '0;
      next_s.frames = '0;
      // Timing is cleared only in the first reset cycle, then keeps running
      if (s.rst_d)
      begin
        next_s.rst_d = 1'b1;
      end
      else
      begin
        next_s.bit_cnt = '0;
        next_s.half = 1'b0;
        // A sync that meets the reset must not cost a frame
        next_s.fs_pend = 1'b0;
        if (fs_rise)
        begin
          next_s.fs_pend = 1'b1;
        end
        next_s.frame_valid = 1'b0;
        next_s.bit_rate_clock = 1'b0;
        next_s.rx_up = '0;
        next_s.rx_dn = '0;
      end
    end
    // Launch on the rising edge that opens a bit
    if (dcl_rise && !next_s.half && next_s.frame_valid)
    begin
      if (!RESETN_I)
      begin
        next_s.up_oe = 1'b1;
        next_s.dn_oe = 1'b1;
        next_s.up_o = !(next_s.bit_cnt[6:3] == `TFSA_CI1_SLOT &&
                        ci_pos(next_s.bit_cnt[2:0]));
        next_s.dn_o = !(next_s.bit_cnt[6:3] == `TFSA_CI0_SLOT &&
                        ci_pos(next_s.bit_cnt[2:0]));
      end
      else
      begin
        {next_s.up_oe, next_s.up_o} = drive_line(1'b1, next_s.bit_cnt, s);
        {next_s.dn_oe, next_s.dn_o} = drive_line(1'b0, next_s.bit_cnt, s);
      end
    end
    if (!RESETN_I && !next_s.frame_valid)
    begin
      next_s.up_oe = 1'b1;
      next_s.dn_oe = 1'b1;
      next_s.up_o = 1'b1;
      next_s.dn_o = 1'b1;
    end
    else if (RESETN_I && (!next_s.frame_valid || s.ifc[`TFSA_IFC_DIS]))
    begin
      next_s.up_oe = 1'b0;
      next_s.dn_oe = 1'b0;
      next_s.up_o = 1'b1;
      next_s.dn_o = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    s <= next_s;
  end

  assign HRDATA_O = s.hrdata;
  assign HREADYOUT_O = s.hreadyout;
  assign HRESP_O = `TFSA_HRESP_OKAY;
  assign BIT_RATE_CLOCK_O = s.bit_rate_clock;
  assign UPSTREAM_LINE_O = s.up_o;
  assign UPSTREAM_LINE_OE_O = s.up_oe;
  assign DOWNSTREAM_LINE_O = s.dn_o;
  assign DOWNSTREAM_LINE_OE_O = s.dn_oe;

  chk_frame_start: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) dcl_rise && (fs_rise || s.fs_pend) |=>
    s.bit_cnt == 7'h00 && !s.half && s.frame_valid)
    else $error("frame did not restart on frame sync");

  chk_bit_clock: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) dcl_rise && s.bit_rate_clock && !fs_rise && !s.fs_pend
    |=> !s.bit_rate_clock)
    else $error("bit clock high for more than one data clock");

  chk_launch_edge: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) s.frame_valid && !s.ifc[`TFSA_IFC_DIS] &&
    $past(RESETN_I) && $changed(s.dn_o) |-> $past(dcl_rise))
    else $error("downstream data changed away from a rising edge");

  chk_capture_edge: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) $changed(s.rx_up) |-> $past(dcl_fall) &&
    $past(s.half))
    else $error("upstream sampled away from a closing falling edge");

  chk_slot_range: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) s.bit_cnt <= `TFSA_BIT_LAST)
    else $error("bit counter beyond twelve slots");

  chk_if_disable: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) s.ifc[`TFSA_IFC_DIS] ##1 RESETN_I |->
    !s.up_oe && !s.dn_oe)
    else $error("line driven while interface disabled");

  chk_input_hold: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) $changed(s.data[0]) |->
    $past(cap_hit[0]) || $past(bus_dat_wr[0]))
    else $error("slot register changed without capture or write");

  chk_capture_value: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) cap_hit[1] && !s.pcr[0][`TFSA_PCR_SWAP] &&
    !s.sps[1][`TFSA_SPS_PORT] |=> s.data[1] == $past(up_byte))
    else $error("captured byte not stored");

  chk_swap_source: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) cap_now && s.pcr[1][`TFSA_PCR_SWAP] &&
    en_bit(s.pcr[1], 1'b0, 1'b1) && s.sps[3][3:0] == s.bit_cnt[6:3] |->
    cap_hit[2])
    else $error("swapped input did not follow partner selection");

  chk_read_wait: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESETN_I) !s.hreadyout |=> s.hreadyout)
    else $error("read wait longer than one cycle");
endmodule

/* File: src/tfsa_regs.svh */
// Register map, field positions and timing constants for the slot access block
`ifndef TFSA_REGS_SVH
`define TFSA_REGS_SVH
`define TFSA_OFF_IFCTRL 8'h00
`define TFSA_OFF_SPS10 8'h04
`define TFSA_OFF_SPS11 8'h08
`define TFSA_OFF_SPS20 8'h0C
`define TFSA_OFF_SPS21 8'h10
`define TFSA_OFF_PCR1 8'h14
`define TFSA_OFF_PCR2 8'h18
`define TFSA_OFF_DAT10 8'h1C
`define TFSA_OFF_DAT11 8'h20
`define TFSA_OFF_DAT20 8'h24
`define TFSA_OFF_DAT21 8'h28
`define TFSA_OFF_STATUS 8'h2C
`define TFSA_IFC_DIS 0
`define TFSA_IFC_ABD 1
`define TFSA_SPS_PORT 7
`define TFSA_PCR_SWAP 0
`define TFSA_PCR_OEN0 1
`define TFSA_PCR_IEN0 2
`define TFSA_PCR_OEN1 3
`define TFSA_PCR_IEN1 4
`define TFSA_ST_VALID 0
`define TFSA_ST_LOST 1
`define TFSA_ST_FCNT_LSB 8
`define TFSA_RST_IFC 2'h0
`define TFSA_RST_SPS 8'h00
`define TFSA_RST_PCR 5'h00
`define TFSA_RST_DATA 8'hFF
`define TFSA_HSIZE_WORD 3'h2
`define TFSA_HRESP_OKAY 1'b0
`define TFSA_BIT_LAST 7'h5F
`define TFSA_POS_LAST 3'h7
`define TFSA_MSB_POS 3'h7
`define TFSA_CI0_SLOT 4'h3
`define TFSA_CI1_SLOT 4'h7
`define TFSA_CI_POS_FIRST 3'h2
`define TFSA_CI_POS_LAST 3'h5
`define TFSA_FRAME_NS 125000
`define TFSA_CLK_NS 8
`endif

/* File: src/tfsa_pkg.sv */
// Types shared by the slot access block
package tfsa_pkg;
  typedef logic [31:0] tfsa_word_type;
  typedef logic [1:0] tfsa_htrans_type;
  typedef logic [2:0] tfsa_hsize_type;
  typedef struct packed {
    logic fs_s1;
    logic fs_s2;
    logic fs_d;
    logic dcl_s1;
    logic dcl_s2;
    logic dcl_d;
    logic up_s1;
    logic up_s2;
    logic dn_s1;
    logic dn_s2;
    logic rst_d;
    logic fs_pend;
    logic frame_valid;
    logic half;
    logic bit_rate_clock;
    logic [6:0] bit_cnt;
    logic [7:0] rx_up;
    logic [7:0] rx_dn;
    logic up_o;
    logic up_oe;
    logic dn_o;
    logic dn_oe;
    logic [1:0] ifc;
    logic [3:0][7:0] sps;
    logic [1:0][4:0] pcr;
    logic [3:0][7:0] data;
    logic [15:0] fcnt;
    logic [7:0] frames;
    logic ad_valid;
    logic ad_write;
    logic [7:0] ad_addr;
    logic hreadyout;
    logic [31:0] hrdata;
  } tfsa_state_type;
endpackage

/* File: tb/tfsa_link_model.sv */
// Far side of the frame bus: clocks, frame sync, line traffic and capture
`timescale 1ns/1ps
module tfsa_link_model
(
  input wire logic up_o_i,
  input wire logic up_oe_i,
  input wire logic dn_o_i,
  input wire logic dn_oe_i,
  input wire logic [11:0][7:0] tx_up_i,
  input wire logic [11:0][7:0] tx_dn_i,
  output logic dcl_o,
  output logic fs_o,
  output logic up_line_o,
  output logic dn_line_o,
  output logic [11:0][7:0] rx_up_o,
  output logic [11:0][7:0] rx_dn_o,
  output logic [15:0] frames_o
);
  logic [7:0] cnt = 8'hBF;
  logic [6:0] bitn;
  initial
  begin
    dcl_o = 1'b0;
    fs_o = 1'b0;
    frames_o = 16'h0;
  end
  always #80 dcl_o = ~dcl_o;
  assign bitn = cnt[7:1];
  // Pull-up lines: a zero from either party wins, released reads high
  assign up_line_o = tx_up_i[bitn[6:3]][3'h7 - bitn[2:0]] &
                     ~(up_oe_i & ~up_o_i);
  assign dn_line_o = tx_dn_i[bitn[6:3]][3'h7 - bitn[2:0]] &
                     ~(dn_oe_i & ~dn_o_i);
  always @(posedge dcl_o)
    cnt <= (cnt == 8'hBF) ? 8'h00 : cnt + 8'h01;
  always @(negedge dcl_o)
  begin
    // Sync rises half a data clock before bit zero, so no start ambiguity
    if (cnt == 8'hBF)
      fs_o <= 1'b1;
    else if (cnt == 8'h01)
      fs_o <= 1'b0;
    if (cnt[0])
    begin
      rx_up_o[bitn[6:3]][3'h7 - bitn[2:0]] <= up_line_o;
      rx_dn_o[bitn[6:3]][3'h7 - bitn[2:0]] <= dn_line_o;
    end
    if (cnt == 8'hBF)
      frames_o <= frames_o + 16'h1;
  end
endmodule

/* File: tb/tfsa_frame_slot_access_test.sv */
// Self-checking bench for the frame slot access block
`timescale 1ns/1ps
`include "tfsa_regs.svh"
module tfsa_frame_slot_access_test;
  import tfsa_pkg::*;
  typedef struct packed {logic dn; logic [3:0] slot; logic [7:0] val;}
    tfsa_exp_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  tfsa_word_type haddr = 32'h0;
  tfsa_word_type hwdata = 32'h0;
  tfsa_word_type hrdata;
  tfsa_htrans_type htrans = 2'h0;
  tfsa_hsize_type hsize = 3'h0;
  logic hready, hresp, bit_rate_clock, up_o, up_oe, dn_o, dn_oe, double_rate_clock, fs, up_w, dn_w;
  logic bcl_d = 1'b0;
  logic rd_flag = 1'b0;
  logic chk_bcl = 1'b0;
  logic [11:0][7:0] tx_up = '1;
  logic [11:0][7:0] tx_dn = '1;
  logic [11:0][7:0] rx_up, rx_dn;
  logic [15:0] frames;
  logic [15:0] last_frames = 16'h0;
  logic [7:0] a, a2, b, c, d, e;
  logic [31:0] rd_q[$];
  tfsa_exp_type ln_q[$];
  tfsa_exp_type x;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 41;
  int bcl_cnt = 0;
  always #4 clk = ~clk;
  tfsa_frame_slot_access #(.FRAME_CYCLES(8000)) dut (.CORE_CLK_I(clk),
    .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .FRAME_SYNC_I(fs), .DOUBLE_RATE_CLOCK_I(double_rate_clock),
    .BIT_RATE_CLOCK_O(bit_rate_clock), .UPSTREAM_LINE_I(up_w), .UPSTREAM_LINE_O(up_o),
    .UPSTREAM_LINE_OE_O(up_oe), .DOWNSTREAM_LINE_I(dn_w),
    .DOWNSTREAM_LINE_O(dn_o), .DOWNSTREAM_LINE_OE_O(dn_oe));
  tfsa_link_model link (.up_o_i(up_o), .up_oe_i(up_oe), .dn_o_i(dn_o),
    .dn_oe_i(dn_oe), .tx_up_i(tx_up), .tx_dn_i(tx_dn), .dcl_o(double_rate_clock),
    .fs_o(fs), .up_line_o(up_w), .dn_line_o(dn_w), .rx_up_o(rx_up),
    .rx_dn_o(rx_dn), .frames_o(frames));
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task limit(input int n);
    if (n >= 5000)
    begin
      miscompares++;
      $display("unexpected at %0t: wait ran out", $time);
      test_done();
    end
  endtask
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    limit(n);
  endtask
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    hsize <= `TFSA_HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    rd_flag <= !w;
    wait_ready();
    rd_flag <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] exp);
    rd_q.push_back(exp);
    ahb(1'b0, ad, 32'h0);
  endtask
  task want(input logic dn, input logic [3:0] s, input logic [7:0] v);
    ln_q.push_back({dn, s, v});
  endtask
  // Returns one cycle after a frame end so the watcher has settled it
  task frame_wait(input int k);
    int n;
    logic [15:0] f;
    repeat (k)
    begin
      f = frames;
      n = 0;
      while (frames === f && n < 5000)
      begin
        @(posedge clk);
        n++;
      end
      limit(n);
      @(posedge clk);
    end
  endtask
  always @(posedge clk)
  begin
    bcl_d <= bit_rate_clock;
    bcl_cnt <= (frames !== last_frames ? 0 : bcl_cnt) +
               (bit_rate_clock === 1'b1 && bcl_d === 1'b0);
    if (rd_flag && hready === 1'b1)
    begin
      check(hrdata, rd_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (frames !== last_frames)
    begin
      last_frames <= frames;
      if (chk_bcl)
        check(bcl_cnt, 32'h60);
      while (ln_q.size() > 0)
      begin
        x = ln_q.pop_front();
        check({24'h0, x.dn ? rx_dn[x.slot] : rx_up[x.slot]},
              {24'h0, x.val});
      end
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(`TFSA_OFF_IFCTRL, 32'h0);
    rd(`TFSA_OFF_SPS21, 32'h0);
    rd(`TFSA_OFF_PCR2, 32'h0);
    rd(`TFSA_OFF_DAT21, 32'hFF);
    ahb(1'b1, 8'h30, 32'hFF);
    rd(8'h30, 32'h0);
    ahb(1'b1, `TFSA_OFF_IFCTRL, 32'h2);
    rd(`TFSA_OFF_IFCTRL, 32'h2);
    a = 8'($random(seed));
    a2 = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    d = 8'($random(seed));
    e = 8'($random(seed));
    // Far side only fills slots no unit drives on that line
    tx_up[2] = a;
    tx_up[11] = e;
    tx_up[9] = b;
    tx_dn[5] = c;
    ahb(1'b1, `TFSA_OFF_SPS10, 32'h02);
    ahb(1'b1, `TFSA_OFF_SPS11, 32'h0B);
    ahb(1'b1, `TFSA_OFF_SPS20, 32'h85);
    ahb(1'b1, `TFSA_OFF_SPS21, 32'h09);
    ahb(1'b1, `TFSA_OFF_PCR1, 32'h1E);
    ahb(1'b1, `TFSA_OFF_PCR2, 32'h1F);
    ahb(1'b1, `TFSA_OFF_IFCTRL, 32'h0);
    frame_wait(2);
    chk_bcl = 1'b1;
    want(1'b1, 4'h2, a);
    want(1'b1, 4'hB, e);
    want(1'b0, 4'h5, b);
    want(1'b1, 4'h9, c);
    repeat (8) @(posedge clk);
    rd(`TFSA_OFF_STATUS, 32'h0201);
    frame_wait(1);
    tx_up[2] = a2;
    want(1'b1, 4'h2, a);
    frame_wait(1);
    want(1'b1, 4'h2, a2);
    frame_wait(1);
    rd(`TFSA_OFF_DAT20, {24'h0, b});
    rd(`TFSA_OFF_DAT21, {24'h0, c});
    ahb(1'b1, `TFSA_OFF_PCR1, 32'h1A);
    tx_up[2] = a;
    frame_wait(2);
    want(1'b1, 4'h2, a2);
    frame_wait(1);
    rd(`TFSA_OFF_DAT10, {24'h0, a2});
    ahb(1'b1, `TFSA_OFF_DAT10, {24'h0, d});
    frame_wait(2);
    want(1'b1, 4'h2, d);
    frame_wait(1);
    ahb(1'b1, `TFSA_OFF_IFCTRL, 32'h1);
    tx_up[11] = ~e;
    frame_wait(2);
    want(1'b1, 4'h2, 8'hFF);
    want(1'b0, 4'h5, 8'hFF);
    frame_wait(1);
    rd(`TFSA_OFF_DAT11, {24'h0, e});
    ahb(1'b1, `TFSA_OFF_IFCTRL, 32'h0);
    tx_up = '1;
    tx_dn = '1;
    frame_wait(1);
    chk_bcl = 1'b0;
    rstn <= 1'b0;
    frame_wait(1);
    chk_bcl = 1'b1;
    want(1'b1, 4'h3, 8'hC3);
    want(1'b0, 4'h7, 8'hC3);
    want(1'b1, 4'h7, 8'hFF);
    want(1'b0, 4'h3, 8'hFF);
    frame_wait(1);
    rstn <= 1'b1;
    rd(`TFSA_OFF_DAT10, 32'hFF);
    rd(`TFSA_OFF_PCR1, 32'h0);
    frame_wait(1);
    want(1'b0, 4'h7, 8'hFF);
    want(1'b1, 4'h2, 8'hFF);
    frame_wait(1);
    test_done();
  end
endmodule
